/* File: remote_link_consts.svh */
// constants for the remote link control register slice
// assumes inclusion by bare name from the design file
`ifndef REMOTE_LINK_CONSTS_SVH
`define REMOTE_LINK_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses = index * 4)
// ----------------------------------------------------------------
`define IDX_PAR_HIGH     8'h55
`define IDX_PAR_LOW      8'h56
`define IDX_SELF_TEST    8'h57
`define IDX_CC_CONFIG    8'h58
`define IDX_RSVD_A       8'h59
`define IDX_RSVD_B       8'h5a
`define IDX_REMOTE_SERIALIZER_IDENTIFIER       8'h5b
`define IDX_CTRL         8'h80
`define IDX_IRQ_STATUS   8'h81
`define IDX_IRQ_MASK     8'h82

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CFG_PASS_ALL     7
`define CFG_PASS_DECODE  6
`define CFG_ACK_ALL      5
`define CFG_BC_CAMERA    4
`define CFG_CRC_GEN      3
`define CFG_RESET        8'h18
`define RATE_2M5         2'h0
`define RATE_1M5625      2'h1
`define CTRL_PARITY_EN   0
`define CTRL_CAMERA_MODE 1
`define CTRL_RESET       8'h03
`define IRQ_PAR_ERR      0
`define IRQ_ID_LOAD      1
`define IRQ_BIST_ERR     2
`define IRQ_BITS         3

// ----------------------------------------------------------------
// back channel bit periods in clk cycles at 125 MHz
// ----------------------------------------------------------------
`define CLK_MHZ_X10000   1250000
`define RATE_2M5_X10000  25000
`define RATE_1M5_X10000  15625
`define BIT_CYC_2M5      (`CLK_MHZ_X10000 / `RATE_2M5_X10000)
`define BIT_CYC_1M5      (`CLK_MHZ_X10000 / `RATE_1M5_X10000)

`endif

/* File: remote_link_pkg.sv */
// types for the remote link control register slice
// assumes remote_link_consts.svh is on the include path
package remote_link_pkg;

  typedef struct packed {
    logic       pass_all;
    logic       pass_decode;
    logic       ack_all;
    logic       bc_camera_enable;
    logic       reverse_crc_gen_enable;
    logic       reserved;
    logic [1:0] reverse_rate_select;
  } cc_config_t;

  typedef struct packed {
    logic       parity_error;
    logic       lock_valid;
    logic       bist_error;
    logic       id_valid;
    logic [6:0] id_value;
  } link_events_t;

  typedef struct packed {
    logic        forward_all;
    logic        forward_decoded;
    logic        auto_ack;
    logic        back_channel_on;
    logic        crc_append;
    logic [10:0] bit_cycles;
    logic        rate_settling;
  } bc_controls_t;

endpackage : remote_link_pkg

/* File: remote_link_ctrl_regs.sv */
// register slice of a link deserializer: parity and self-test counts,
// control channel setup and remote serializer identifier capture.
// assumes an avalon-mm master on clk and event pulses from the receiver.
// Function
// - reading the parity count low byte clears it
// - parity errors counted since last lock or low-byte read
// - self-test error count readable as an 8-bit read-only register
// - pass-all bit forwards every I2C transaction to the serializer
// - decode pass-through forwards only address-matched transactions
// - acknowledge-all bit acknowledges every I2C write automatically
// - camera mode back channel follows enable bit; display always on
// - CRC generator bit appends CRC to back channel; resets to one
// - two-bit rate field; 00 is 2.5 Mbps, 01 is 1.5625 Mbps
// - errors after rate change are tolerated by both ends
// - serializer identifier normally loaded from remote information
// - freeze bit stops auto loading and keeps written identifier
// - reading the low byte also clears the high byte
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "remote_link_consts.svh"

module remote_link_ctrl_regs (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [9:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic      [1:0]                  avs_response,
  output logic                             avs_waitrequest,
  input  wire remote_link_pkg::link_events_t events,
  input  wire logic                        decode_match,
  output remote_link_pkg::bc_controls_t    controls,
  output logic                             parity_check_enable,
  output logic                             irq
);

  // ----------------------------------------------------------------
  // bus access: one wait cycle, answer on the second cycle
  // ----------------------------------------------------------------
  logic        ack;
  logic        next_ack;
  logic [7:0]  idx;
  logic        word_ok;
  logic        rd_take;
  logic        wr_take;
  logic        lane0;

  assign idx     = avs_address[9:2];
  assign word_ok = (avs_address[1:0] == 2'h0);
  assign rd_take = avs_read && ack;
  assign wr_take = avs_write && ack && lane0;
  assign lane0   = avs_byteenable[0];
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  always_comb begin
    next_ack = (avs_read || avs_write) && !ack;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  // ----------------------------------------------------------------
  // counters: parity error count (16 bits) and self-test count
  // ----------------------------------------------------------------
  logic [15:0] par_count;
  logic [15:0] next_par_count;
  logic [7:0]  bist_count;
  logic [7:0]  next_bist_count;
  logic        low_read;

  assign low_read = rd_take && word_ok && (idx == `IDX_PAR_LOW);

  always_comb begin
    next_par_count = par_count;
    // lock or low read restarts the count; an error in that
    // cycle is the first of the new count so it is not lost
    if (low_read || events.lock_valid) begin
      next_par_count = {15'h0000, events.parity_error};
    end else if (events.parity_error &&
                 par_count != 16'hffff) begin
      next_par_count = par_count + 16'h0001;
    end
    next_bist_count = bist_count;
    if (events.bist_error && bist_count != 8'hff) begin
      next_bist_count = bist_count + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_count  <= 16'h0000;
      bist_count <= 8'h00;
    end else begin
      par_count  <= next_par_count;
      bist_count <= next_bist_count;
    end
  end

  // ----------------------------------------------------------------
  // configuration, identifier, control and interrupt registers
  // ----------------------------------------------------------------
  remote_link_pkg::cc_config_t cfg;
  remote_link_pkg::cc_config_t next_cfg;
  logic [7:0]  rsvd_a;
  logic [7:0]  next_rsvd_a;
  logic [7:0]  rsvd_b;
  logic [7:0]  next_rsvd_b;
  logic [6:0]  remote_serializer_identifier;
  logic [6:0]  next_remote_serializer_identifier;
  logic        id_freeze;
  logic        next_id_freeze;
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [`IRQ_BITS-1:0] irq_status;
  logic [`IRQ_BITS-1:0] next_irq_status;
  logic [`IRQ_BITS-1:0] irq_mask;
  logic [`IRQ_BITS-1:0] next_irq_mask;
  logic [`IRQ_BITS-1:0] irq_set;
  logic [7:0]  wbyte;
  logic        wsel_cfg;
  logic        wsel_id;
  logic        wsel_st;

  assign wbyte    = avs_writedata[7:0];
  assign wsel_cfg = wr_take && word_ok && (idx == `IDX_CC_CONFIG);
  assign wsel_id  = wr_take && word_ok && (idx == `IDX_REMOTE_SERIALIZER_IDENTIFIER);
  assign wsel_st  = wr_take && word_ok && (idx == `IDX_IRQ_STATUS);
  assign irq_set  = {events.bist_error,
                     events.id_valid && !id_freeze,
                     events.parity_error};

  always_comb begin
    next_cfg        = cfg;
    next_rsvd_a     = rsvd_a;
    next_rsvd_b     = rsvd_b;
    next_remote_serializer_identifier     = remote_serializer_identifier;
    next_id_freeze  = id_freeze;
    next_ctrl       = ctrl;
    next_irq_mask   = irq_mask;
    if (wsel_cfg) begin
      next_cfg = remote_link_pkg::cc_config_t'(wbyte);
    end
    if (wr_take && word_ok && idx == `IDX_RSVD_A) begin
      next_rsvd_a = wbyte;
    end
    if (wr_take && word_ok && idx == `IDX_RSVD_B) begin
      next_rsvd_b = wbyte;
    end
    if (wr_take && word_ok && idx == `IDX_CTRL) begin
      next_ctrl = wbyte;
    end
    if (wr_take && word_ok && idx == `IDX_IRQ_MASK) begin
      next_irq_mask = wbyte[`IRQ_BITS-1:0];
    end
    // a software write wins over a same-cycle remote load
    if (wsel_id) begin
      next_remote_serializer_identifier    = wbyte[7:1];
      next_id_freeze = wbyte[0];
    end else if (events.id_valid && !id_freeze) begin
      next_remote_serializer_identifier = events.id_value;
    end
    next_irq_status = irq_status;
    if (wsel_st) begin
      next_irq_status = irq_status & ~wbyte[`IRQ_BITS-1:0];
    end
    next_irq_status = next_irq_status | irq_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg        <= remote_link_pkg::cc_config_t'(`CFG_RESET);
      rsvd_a     <= 8'h00;
      rsvd_b     <= 8'h00;
      remote_serializer_identifier     <= 7'h00;
      id_freeze  <= 1'b0;
      ctrl       <= `CTRL_RESET;
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      cfg        <= next_cfg;
      rsvd_a     <= next_rsvd_a;
      rsvd_b     <= next_rsvd_b;
      remote_serializer_identifier     <= next_remote_serializer_identifier;
      id_freeze  <= next_id_freeze;
      ctrl       <= next_ctrl;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  assign irq = |(irq_status & irq_mask);
  assign parity_check_enable = ctrl[`CTRL_PARITY_EN];

  // ----------------------------------------------------------------
  // rate change settle window: errors are expected, flagged to link
  // ----------------------------------------------------------------
  logic [5:0] settle;
  logic [5:0] next_settle;

  always_comb begin
    next_settle = settle;
    if (wsel_cfg && wbyte[1:0] != cfg.reverse_rate_select) begin
      next_settle = 6'h3f;
    end else if (settle != 6'h00) begin
      next_settle = settle - 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle <= 6'h00;
    end else begin
      settle <= next_settle;
    end
  end

  // ----------------------------------------------------------------
  // controls toward the control channel and back channel
  // ----------------------------------------------------------------
  remote_link_pkg::bc_controls_t next_controls;

  always_comb begin
    next_controls.forward_all     = cfg.pass_all;
    next_controls.forward_decoded = cfg.pass_decode &&
                                    decode_match;
    next_controls.auto_ack        = cfg.ack_all;
    next_controls.back_channel_on =
      !ctrl[`CTRL_CAMERA_MODE] || cfg.bc_camera_enable;
    next_controls.crc_append = cfg.reverse_crc_gen_enable;
    // reserved codes keep the default rate
    next_controls.bit_cycles =
      (cfg.reverse_rate_select == `RATE_1M5625) ?
      11'(`BIT_CYC_1M5) : 11'(`BIT_CYC_2M5);
    next_controls.rate_settling = (settle != 6'h00);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      controls <= '0;
    end else begin
      controls <= next_controls;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [1:0]  next_resp;
  logic        hit;

  always_comb begin
    next_rdata = 32'h0000_0000;
    hit        = word_ok;
    unique case (idx)
      `IDX_PAR_HIGH:   next_rdata[7:0] = par_count[15:8];
      `IDX_PAR_LOW:    next_rdata[7:0] = par_count[7:0];
      `IDX_SELF_TEST:  next_rdata[7:0] = bist_count;
      `IDX_CC_CONFIG:  next_rdata[7:0] = cfg;
      `IDX_RSVD_A:     next_rdata[7:0] = rsvd_a;
      `IDX_RSVD_B:     next_rdata[7:0] = rsvd_b;
      `IDX_REMOTE_SERIALIZER_IDENTIFIER:     next_rdata[7:0] = {remote_serializer_identifier, id_freeze};
      `IDX_CTRL:       next_rdata[7:0] = ctrl;
      `IDX_IRQ_STATUS: next_rdata[`IRQ_BITS-1:0] = irq_status;
      `IDX_IRQ_MASK:   next_rdata[`IRQ_BITS-1:0] = irq_mask;
      default:         hit = 1'b0;
    endcase
    if (!hit) begin
      next_rdata = 32'h0000_0000;
    end
    next_resp = hit ? 2'h0 : 2'h2;
  end

  // read data settle during the wait cycle and stand when waitrequest
  // drops; registered to keep the data output off combinational paths
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else begin
      avs_readdata <= next_rdata;
      avs_response <= next_resp;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence low_byte_read;
    rd_take && word_ok && idx == `IDX_PAR_LOW;
  endsequence

  a_low_read_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    low_byte_read ##1 1'b1 |-> par_count[7:0] <= 8'h01)
    else $error("low parity byte not cleared by read");

  a_high_read_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    low_byte_read |=> par_count[15:8] == 8'h00)
    else $error("high parity byte not cleared by low read");

  a_parity_counts: assert property (
    @(posedge clk) disable iff (!rst_n)
    events.parity_error && !low_read && !events.lock_valid &&
    par_count != 16'hffff |=> par_count == $past(par_count) + 16'h0001)
    else $error("parity error not counted");

  a_bist_counts: assert property (
    @(posedge clk) disable iff (!rst_n)
    !events.bist_error |=> bist_count == $past(bist_count))
    else $error("self-test count moved without error");

  a_bist_steps: assert property (
    @(posedge clk) disable iff (!rst_n)
    events.bist_error && bist_count != 8'hff |=>
    bist_count == $past(bist_count) + 8'h01)
    else $error("self-test error not counted");

  a_pass_all: assert property (
    @(posedge clk) disable iff (!rst_n)
    wsel_cfg ##1 1'b1 |=> controls.forward_all == $past(wbyte[7], 2))
    else $error("pass-all not applied");

  a_pass_decode: assert property (
    @(posedge clk) disable iff (!rst_n)
    !decode_match |=> !controls.forward_decoded)
    else $error("unmatched transaction forwarded");

  a_auto_ack: assert property (
    @(posedge clk) disable iff (!rst_n)
    controls.auto_ack == $past(cfg.ack_all))
    else $error("auto ack does not follow config");

  a_display_bc: assert property (
    @(posedge clk) disable iff (!rst_n)
    !$past(ctrl[`CTRL_CAMERA_MODE]) |-> controls.back_channel_on)
    else $error("back channel off in display mode");

  // controls still hold their reset zeros one edge after release
  a_camera_bc: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(ctrl[`CTRL_CAMERA_MODE]) |->
    controls.back_channel_on == $past(cfg.bc_camera_enable))
    else $error("camera back channel does not follow enable");

  a_crc_follows: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n) |->
    controls.crc_append == $past(cfg.reverse_crc_gen_enable))
    else $error("crc append does not follow config");

  a_rate_select: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(cfg.reverse_rate_select) == `RATE_1M5625 |->
    controls.bit_cycles == 11'd80)
    else $error("slow rate bit period wrong");

  a_settle_window: assert property (
    @(posedge clk) disable iff (!rst_n)
    wsel_cfg && wbyte[1:0] != cfg.reverse_rate_select |=>
    ##1 controls.rate_settling [*8])
    else $error("rate settle window missing");

  a_id_frozen: assert property (
    @(posedge clk) disable iff (!rst_n)
    id_freeze && !wsel_id |=> $stable(remote_serializer_identifier))
    else $error("frozen identifier changed");

  a_id_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    events.id_valid && !id_freeze && !wsel_id |=>
    remote_serializer_identifier == $past(events.id_value))
    else $error("identifier not loaded");

endmodule : remote_link_ctrl_regs

/* File: remote_serializer_model.sv */
// model of the remote serializer across the control channel
// assumes its tasks are called by one bench process, just after an edge
`timescale 1ns/1ns

module remote_serializer_model (
  input  wire logic                     clk,
  output remote_link_pkg::link_events_t ev,
  output logic                          match
);
  initial begin
    ev    = '0;
    match = 1'b0;
  end

  // ----------------------------------------------------------------
  // event pulses, one cycle high, one low, so each pulse is distinct
  // ----------------------------------------------------------------
  // errors keep coming during a rate change; nothing here stops
  task automatic parity(input int n);
    repeat (n) begin
      @(posedge clk) ev.parity_error <= 1'b1;
      @(posedge clk) ev.parity_error <= 1'b0;
    end
  endtask : parity

  task automatic lock();
    @(posedge clk) ev.lock_valid <= 1'b1;
    @(posedge clk) ev.lock_valid <= 1'b0;
  endtask : lock

  task automatic bist();
    @(posedge clk) ev.bist_error <= 1'b1;
    @(posedge clk) ev.bist_error <= 1'b0;
  endtask : bist

  task automatic send_id(input logic [6:0] v);
    @(posedge clk) begin
      ev.id_valid <= 1'b1;
      ev.id_value <= v;
    end
    // stale id is inverted so a missed valid check shows up
    @(posedge clk) begin
      ev.id_valid <= 1'b0;
      ev.id_value <= ~v;
    end
  endtask : send_id

  task automatic set_match(input logic m);
    @(posedge clk) match <= m;
  endtask : set_match
endmodule : remote_serializer_model

/* File: tb_top.sv */
// self-checking bench for the remote link register slice
// assumes the design files and the serializer model are compiled first
`timescale 1ns/1ns
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))

module tb_top;
  logic                          clk            = 1'b0;
  logic                          rst_n;
  logic [9:0]                    avs_address;
  logic                          avs_read;
  logic                          avs_write;
  logic [31:0]                   avs_writedata;
  logic [3:0]                    avs_byteenable;
  logic [31:0]                   avs_readdata;
  logic [1:0]                    avs_response;
  logic                          avs_waitrequest;
  remote_link_pkg::link_events_t ev;
  remote_link_pkg::bc_controls_t controls;
  logic                          decode_match;
  logic                          parity_check_enable;
  logic                          irq;
  logic [31:0]                   rd;
  logic [1:0]                    rs;
  int                            mismatches = 0;
  int                            num_checks = 0;
  int                            cycles     = 0;

  typedef struct packed {
    logic       w;
    logic [7:0] idx;
    logic [7:0] d;
    logic [1:0] r;
  } row_t;

  // reads carry the expected data, writes the data to send
  localparam row_t rows [15] = '{
    {1'h0, 8'h56, 8'h00, 2'h0}, {1'h0, 8'h57, 8'h00, 2'h0},
    {1'h0, 8'h58, 8'h18, 2'h0}, {1'h0, 8'h5b, 8'h00, 2'h0},
    {1'h0, 8'h80, 8'h03, 2'h0}, {1'h0, 8'h81, 8'h00, 2'h0},
    {1'h0, 8'h82, 8'h00, 2'h0}, {1'h1, 8'h59, 8'ha5, 2'h0},
    {1'h0, 8'h59, 8'ha5, 2'h0}, {1'h1, 8'h5a, 8'h5a, 2'h0},
    {1'h0, 8'h5a, 8'h5a, 2'h0}, {1'h1, 8'h40, 8'hff, 2'h0},
    {1'h0, 8'h40, 8'h00, 2'h2}, {1'h1, 8'h57, 8'h77, 2'h0},
    {1'h0, 8'h57, 8'h00, 2'h0}};

  always #4 clk = ~clk;

  remote_link_ctrl_regs i_dut (
    .clk                 (clk),
    .rst_n               (rst_n),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_response        (avs_response),
    .avs_waitrequest     (avs_waitrequest),
    .events              (ev),
    .decode_match        (decode_match),
    .controls            (controls),
    .parity_check_enable (parity_check_enable),
    .irq                 (irq)
  );

  remote_serializer_model i_ser (
    .clk   (clk),
    .ev    (ev),
    .match (decode_match)
  );

  // ----------------------------------------------------------------
  // checking, bus cycles and verdict
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // waitrequest and read data are taken just after the rising edge,
  // before the slave's flops update, so they are the sampled values
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_read       <= ~w;
    avs_write      <= w;
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer

  task automatic rdc(input string n, input logic [7:0] idx, e);
    xfer(1'b0, idx, 8'h00, 4'h0);
    `CHK(n, e, rd);
    `CHK(n, 2'h0, rs);
    @(negedge clk);
  endtask : rdc

  task automatic wr(input logic [7:0] idx, d);
    xfer(1'b1, idx, d, 4'h1);
    repeat (2) @(negedge clk);
  endtask : wr

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n          <= 1'b0;
    avs_address    <= 10'h000;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    avs_writedata  <= 32'h0000_0000;
    avs_byteenable <= 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // controls are registered: the reset config shows one edge later
    repeat (2) @(negedge clk);
    `CHK("par_chk_rst", 1'b1, parity_check_enable);
    `CHK("bc_rst", 1'b1, controls.back_channel_on);
    `CHK("crc_rst", 1'b1, controls.crc_append);
    `CHK("rate_rst", 11'h032, controls.bit_cycles);
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].idx, rows[i].d, 4'h1);
      if (!rows[i].w) begin
        `CHK("row_data", rows[i].d, rd);
        `CHK("row_resp", rows[i].r, rs);
      end
    end
    wr(8'h58, 8'h20); // auto ack goes on before the rate changes
    wr(8'h58, 8'he1);
    `CHK("fwd_all", 1'b1, controls.forward_all);
    `CHK("ack_all", 1'b1, controls.auto_ack);
    `CHK("crc_off", 1'b0, controls.crc_append);
    `CHK("bc_cam_off", 1'b0, controls.back_channel_on);
    `CHK("rate_slow", 11'h050, controls.bit_cycles);
    `CHK("settling", 1'b1, controls.rate_settling);
    `CHK("fwd_dec_nm", 1'b0, controls.forward_decoded);
    i_ser.set_match(1'b1);
    repeat (2) @(negedge clk);
    `CHK("fwd_dec_m", 1'b1, controls.forward_decoded);
    wr(8'h58, 8'h02);
    `CHK("fwd_all_off", 1'b0, controls.forward_all);
    `CHK("fwd_dec_off", 1'b0, controls.forward_decoded);
    `CHK("ack_off", 1'b0, controls.auto_ack);
    `CHK("rate_rsvd", 11'h032, controls.bit_cycles);
    wr(8'h80, 8'h01);
    `CHK("bc_display", 1'b1, controls.back_channel_on);
    repeat (70) @(negedge clk);
    `CHK("settled", 1'b0, controls.rate_settling);
    i_ser.parity(2);
    i_ser.lock();
    i_ser.parity(258);
    wr(8'h80, 8'h00); // checker off before the count is read
    `CHK("par_chk_off", 1'b0, parity_check_enable);
    rdc("par_hi", 8'h55, 8'h01);
    rdc("par_lo", 8'h56, 8'h02);
    rdc("par_hi_clr", 8'h55, 8'h00);
    rdc("par_lo_clr", 8'h56, 8'h00);
    `CHK("irq_masked", 1'b0, irq);
    wr(8'h82, 8'h01);
    `CHK("irq_on", 1'b1, irq);
    wr(8'h81, 8'h01);
    `CHK("irq_clr", 1'b0, irq);
    wr(8'h82, 8'h07);
    i_ser.bist();
    i_ser.bist();
    rdc("bist", 8'h57, 8'h02);
    i_ser.send_id(7'h2a);
    rdc("id_load", 8'h5b, 8'h54);
    rdc("status", 8'h81, 8'h06);
    `CHK("irq_bist_id", 1'b1, irq);
    wr(8'h5b, 8'h33);
    i_ser.send_id(7'h11);
    rdc("id_frozen", 8'h5b, 8'h33);
    xfer(1'b1, 8'h5b, 8'h00, 4'h0);
    rdc("id_be_off", 8'h5b, 8'h33);
    wr(8'h5b, 8'h00);
    i_ser.send_id(7'h05);
    rdc("id_thaw", 8'h5b, 8'h0a);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc("bist_rst", 8'h57, 8'h00);
    rdc("id_rst", 8'h5b, 8'h00);
    `CHK("irq_rst", 1'b0, irq);
    print_verdict();
  end
endmodule : tb_top
